// file: cwa_pkg.sv
package cwa_pkg;
  localparam int unsigned CWA_SOCKETS = 2;
  localparam int unsigned CWA_BANK_DEPTH = 64;
  localparam int unsigned CWA_IO_WINDOWS = 2;
  localparam int unsigned CWA_MEM_WINDOWS = 5;
  localparam int unsigned CWA_SYNC_STAGES = 3;
  localparam int unsigned CWA_IDX_SOCKET_BIT = 6;

  // register indices within one socket; socket B sits 40h higher
  localparam logic [5:0] IDX_WIN_ENABLE = 6'h06;
  localparam logic [5:0] IDX_IO_TIMING_CTL = 6'h07;
  localparam logic [5:0] IDX_IO_WIN0_START_LO = 6'h08;
  localparam logic [5:0] IDX_IO_WIN0_START_HI = 6'h09;
  localparam logic [5:0] IDX_IO_WIN0_END_LO = 6'h0a;
  localparam logic [5:0] IDX_IO_WIN0_END_HI = 6'h0b;
  localparam logic [5:0] IDX_IO_WIN1_START_LO = 6'h0c;
  localparam logic [5:0] IDX_IO_WIN1_START_HI = 6'h0d;
  localparam logic [5:0] IDX_IO_WIN1_END_LO = 6'h0e;
  localparam logic [5:0] IDX_IO_WIN1_END_HI = 6'h0f;
  localparam logic [5:0] IDX_MEM_WIN0_START_LO = 6'h10;
  localparam logic [5:0] IDX_MEM_WIN0_START_HI_ATTR = 6'h11;
  localparam logic [5:0] IDX_MEM_WIN1_START_LO = 6'h18;
  localparam logic [5:0] IDX_MEM_WIN1_START_HI_ATTR = 6'h19;
  localparam logic [5:0] IDX_MEM_WIN2_START_LO = 6'h20;
  localparam logic [5:0] IDX_MEM_WIN2_START_HI_ATTR = 6'h21;
  localparam logic [5:0] IDX_MEM_WIN3_START_LO = 6'h28;
  localparam logic [5:0] IDX_MEM_WIN3_START_HI_ATTR = 6'h29;
  localparam logic [5:0] IDX_MEM_WIN4_START_LO = 6'h30;
  localparam logic [5:0] IDX_MEM_WIN4_START_HI_ATTR = 6'h31;
  localparam logic [5:0] IO_WIN_STRIDE = 6'h04;
  localparam logic [2:0] MEM_FIRST_GROUP = 3'h2;
  localparam logic [2:0] MEM_LAST_GROUP = 3'h6;
  // byte positions inside one 8-index memory window group
  localparam logic [2:0] MEM_OFS_START_LO = 3'h0;
  localparam logic [2:0] MEM_OFS_START_HI = 3'h1;
  localparam logic [2:0] MEM_OFS_END_LO = 3'h2;
  localparam logic [2:0] MEM_OFS_END_HI = 3'h3;
  localparam logic [2:0] MEM_OFS_LIMIT = 3'h4;

  localparam logic [7:0] CWA_REG_RESET = 8'h00;
  localparam logic [7:0] WMASK_FULL = 8'hff;
  localparam logic [7:0] WMASK_NONE = 8'h00;
  localparam logic [7:0] WMASK_WIN_ENABLE = 8'hdf;
  localparam logic [7:0] WMASK_MEM_END_HI = 8'hcf;

  // window enable bits
  localparam int unsigned EN_IO0_BIT = 6;
  // io timing control: one nibble per window, window 1 in the upper nibble
  localparam int unsigned IOC_SIZE = 0;
  localparam int unsigned IOC_AUTO = 1;
  localparam int unsigned IOC_FAST8 = 2;
  localparam int unsigned IOC_WS16 = 3;
  // memory start high byte / end high byte fields
  localparam int unsigned MEM_SH_SIZE = 7;
  localparam int unsigned MEM_SH_FAST = 6;
  localparam int unsigned MEM_EH_WS_MSB = 7;
  localparam int unsigned MEM_EH_WS_LSB = 6;
  localparam int unsigned MEM_GRAN_LSB = 12;

  typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} cwa_bus_state_t;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic [23:0] addr;
  } cwa_host_req_t;

  typedef struct packed {
    logic claim;
    logic is_io;
    logic [2:0] win;
    logic wide;
    logic fast;
    logic [1:0] wait_add;
  } cwa_cycle_attr_t;
endpackage : cwa_pkg

// file: cwa_window_bank.sv
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module cwa_window_bank import cwa_pkg::*; (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // register bus, byte address, one register per aligned word
  input wire logic [8:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // host cycle to be decoded against both sockets
  input wire cwa_host_req_t HOST_REQ,
  // card width request pins, active low, one per socket
  input wire logic [CWA_SOCKETS-1:0] CARD_IO_WIDTH_REQUEST_N,
  // per-socket claim and cycle attributes
  output cwa_cycle_attr_t [CWA_SOCKETS-1:0] CYC_ATTR
);

  // mapped bits of each index; zero mask marks an unmapped index
  function automatic logic [7:0] idx_wmask(input logic [5:0] idx);
    logic [7:0] m;
    m = WMASK_NONE;
    if (idx == IDX_WIN_ENABLE) begin
      m = WMASK_WIN_ENABLE;
    end else if (idx >= IDX_IO_TIMING_CTL && idx <= IDX_IO_WIN1_END_HI) begin
      m = WMASK_FULL;
    end else if (idx[5:3] >= MEM_FIRST_GROUP && idx[5:3] <= MEM_LAST_GROUP
                 && idx[2:0] < MEM_OFS_LIMIT) begin
      m = (idx[2:0] == MEM_OFS_END_HI) ? WMASK_MEM_END_HI : WMASK_FULL;
    end
    return m;
  endfunction : idx_wmask

  function automatic logic [5:0] mem_idx(input logic [2:0] win, input logic [2:0] ofs);
    return {win + MEM_FIRST_GROUP, ofs};
  endfunction : mem_idx

  logic [7:0] bank [CWA_SOCKETS][CWA_BANK_DEPTH];
  cwa_bus_state_t bus_state;
  logic acc_sock;
  logic [5:0] acc_idx;
  logic wr_fire;
  cwa_cycle_attr_t next_attr [CWA_SOCKETS];
  logic [CWA_SOCKETS-1:0] card_wide;

  // top index bit picks the socket copy
  assign acc_sock = AVS_ADDRESS[CWA_IDX_SOCKET_BIT + 2];
  assign acc_idx = AVS_ADDRESS[7:2];
  // only the low lane carries a byte register; upper lanes are dropped
  assign wr_fire = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];

  // bus handshake: one wait cycle, then a single answer cycle
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      bus_state <= BUS_IDLE;
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            bus_state <= BUS_ACK;
            AVS_WAITREQUEST <= 1'b0;
          end
        end
        BUS_ACK: begin
          bus_state <= BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
        default: begin
          bus_state <= BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  // read data is captured as the answer is raised and held until the next read
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      AVS_READDATA <= '0;
    end else if (bus_state == BUS_IDLE && AVS_READ) begin
      AVS_READDATA <= {24'h000000, bank[acc_sock][acc_idx]};
    end
  end

  for (genvar s = 0; s < CWA_SOCKETS; s++) begin : g_sock
    logic [CWA_SYNC_STAGES-1:0] sync;
    logic card_wide_n;
    logic [CWA_IO_WINDOWS-1:0] io_hit;
    logic [CWA_MEM_WINDOWS-1:0] mem_hit;
    logic [7:0] en;
    logic [7:0] ctl;
    cwa_cycle_attr_t attr_n;

    for (genvar i = 0; i < CWA_BANK_DEPTH; i++) begin : g_idx
      localparam logic [7:0] MASK = idx_wmask(6'(i));
      // scratch bits of memory start high bytes are stored and read back unchanged; bits outside the mask read as zero
      always_ff @(posedge SYS_CLK) begin
        if (RST) begin
          bank[s][i] <= CWA_REG_RESET;
        end else if (wr_fire && acc_sock == 1'(s) && acc_idx == 6'(i)) begin
          bank[s][i] <= AVS_WRITEDATA[7:0] & MASK;
        end
      end
    end

    // pin crosses three stages; a change is taken once the last two agree
    always_ff @(posedge SYS_CLK) begin
      if (RST) begin
        sync <= '1;
        card_wide_n <= 1'b1;
      end else begin
        sync <= {sync[CWA_SYNC_STAGES-2:0], CARD_IO_WIDTH_REQUEST_N[s]};
        if (sync[1] == sync[2]) begin
          card_wide_n <= sync[2];
        end
      end
    end
    assign card_wide[s] = !card_wide_n;

    assign en = bank[s][IDX_WIN_ENABLE];
    assign ctl = bank[s][IDX_IO_TIMING_CTL];

    for (genvar k = 0; k < CWA_IO_WINDOWS; k++) begin : g_io
      localparam logic [5:0] B = 6'(IDX_IO_WIN0_START_LO + 6'(k) * IO_WIN_STRIDE);
      logic [15:0] io_start;
      logic [15:0] io_end;
      // start address from its two bytes
      assign io_start = {bank[s][B + 6'h01], bank[s][B]};
      // end address from its two bytes
      assign io_end = {bank[s][B + 6'h03], bank[s][B + 6'h02]};
      // inclusive range on the 16-bit io address
      assign io_hit[k] = en[EN_IO0_BIT + k] && HOST_REQ.addr[15:0] >= io_start
                         && HOST_REQ.addr[15:0] <= io_end;
    end

    for (genvar j = 0; j < CWA_MEM_WINDOWS; j++) begin : g_mem
      logic [11:0] m_start;
      logic [11:0] m_end;
      assign m_start = {bank[s][mem_idx(3'(j), MEM_OFS_START_HI)][3:0],
                        bank[s][mem_idx(3'(j), MEM_OFS_START_LO)]};
      // end compared at the same 4 KB grain
      assign m_end = {bank[s][mem_idx(3'(j), MEM_OFS_END_HI)][3:0],
                      bank[s][mem_idx(3'(j), MEM_OFS_END_LO)]};
      // inclusive range on address bits 23-12
      assign mem_hit[j] = en[j] && HOST_REQ.addr[23:MEM_GRAN_LSB] >= m_start
                          && HOST_REQ.addr[23:MEM_GRAN_LSB] <= m_end;
    end

    // overlapping windows: the lowest numbered one wins
    always_comb begin
      logic [3:0] nib;
      logic [7:0] sh;
      logic [7:0] eh;
      nib = '0;
      sh = '0;
      eh = '0;
      attr_n = '0;
      attr_n.is_io = HOST_REQ.is_io;
      if (HOST_REQ.valid && HOST_REQ.is_io) begin
        for (int k = CWA_IO_WINDOWS - 1; k >= 0; k--) begin
          if (io_hit[k]) begin
            attr_n.claim = 1'b1;
            attr_n.win = 3'(k);
          end
        end
        nib = attr_n.win[0] ? ctl[7:4] : ctl[3:0];
        // automatic sizing follows the card for window 1
        // automatic sizing follows the card for window 0
        // size bit counts only without automatic sizing
        // size bit counts only without automatic sizing
        attr_n.wide = nib[IOC_AUTO] ? card_wide[s] : nib[IOC_SIZE];
        // fast timing only for 8-bit cycles
        // fast timing only for 8-bit cycles
        attr_n.fast = !attr_n.wide && nib[IOC_FAST8];
        // extra wait only for 16-bit cycles
        // extra wait only for 16-bit cycles
        attr_n.wait_add = {1'b0, attr_n.wide && nib[IOC_WS16]};
      end else if (HOST_REQ.valid) begin
        for (int j = CWA_MEM_WINDOWS - 1; j >= 0; j--) begin
          if (mem_hit[j]) begin
            attr_n.claim = 1'b1;
            attr_n.win = 3'(j);
          end
        end
        sh = bank[s][mem_idx(attr_n.win, MEM_OFS_START_HI)];
        eh = bank[s][mem_idx(attr_n.win, MEM_OFS_END_HI)];
        // width from start high bit 7
        attr_n.wide = sh[MEM_SH_SIZE];
        // three cycles if 8-bit, two if 16-bit
        attr_n.fast = sh[MEM_SH_FAST];
        // programmed wait states add only to 16-bit memory cycles
        attr_n.wait_add = attr_n.wide ? eh[MEM_EH_WS_MSB:MEM_EH_WS_LSB] : 2'h0;
      end
      if (!attr_n.claim) begin
        attr_n = '0;
      end
    end
    assign next_attr[s] = attr_n;
  end

  // attributes for the cycle presented on the previous edge
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      CYC_ATTR <= '0;
    end else begin
      for (int s = 0; s < CWA_SOCKETS; s++) begin
        CYC_ATTR[s] <= next_attr[s];
      end
    end
  end

  a_io1_wait16: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && HOST_REQ.is_io && g_sock[0].io_hit == 2'b10
    |=> CYC_ATTR[0].win == 3'h1
        && CYC_ATTR[0].wait_add == {1'b0, CYC_ATTR[0].wide && $past(g_sock[0].ctl[7])})
    else $error("io window 1 16-bit wait state wrong");

  a_io1_fast8: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && HOST_REQ.is_io && g_sock[0].io_hit == 2'b10
    |=> CYC_ATTR[0].fast == (!CYC_ATTR[0].wide && $past(g_sock[0].ctl[6])))
    else $error("io window 1 8-bit fast timing wrong");

  a_io1_auto_size: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && HOST_REQ.is_io && g_sock[0].io_hit == 2'b10 && g_sock[0].ctl[5]
    |=> CYC_ATTR[0].wide == $past(card_wide[0]))
    else $error("io window 1 width ignores card request");

  a_io1_fixed_size: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && HOST_REQ.is_io && g_sock[0].io_hit == 2'b10 && !g_sock[0].ctl[5]
    |=> CYC_ATTR[0].claim && CYC_ATTR[0].wide == $past(g_sock[0].ctl[4]))
    else $error("io window 1 fixed width wrong");

  a_io0_wait16: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && HOST_REQ.is_io && g_sock[0].io_hit[0]
    |=> CYC_ATTR[0].win == 3'h0
        && CYC_ATTR[0].wait_add == {1'b0, CYC_ATTR[0].wide && $past(g_sock[0].ctl[3])})
    else $error("io window 0 16-bit wait state wrong");

  a_io0_fast8: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && HOST_REQ.is_io && g_sock[0].io_hit[0]
    |=> CYC_ATTR[0].fast == (!CYC_ATTR[0].wide && $past(g_sock[0].ctl[2])))
    else $error("io window 0 8-bit fast timing wrong");

  a_io0_auto_size: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && HOST_REQ.is_io && g_sock[0].io_hit[0] && g_sock[0].ctl[1]
    |=> CYC_ATTR[0].wide == $past(card_wide[0]))
    else $error("io window 0 width ignores card request");

  a_io0_fixed_size: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && HOST_REQ.is_io && g_sock[0].io_hit[0] && !g_sock[0].ctl[1]
    |=> CYC_ATTR[0].claim && CYC_ATTR[0].wide == $past(g_sock[0].ctl[0]))
    else $error("io window 0 fixed width wrong");

  a_mem2_width: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && !HOST_REQ.is_io && g_sock[0].mem_hit[2:0] == 3'h4
    |=> CYC_ATTR[0].win == 3'h2
        && CYC_ATTR[0].wide == $past(bank[0][IDX_MEM_WIN2_START_HI_ATTR][MEM_SH_SIZE]))
    else $error("memory window 2 width wrong");

  a_mem2_fast: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && !HOST_REQ.is_io && g_sock[0].mem_hit[2:0] == 3'h4
    |=> CYC_ATTR[0].fast == $past(bank[0][IDX_MEM_WIN2_START_HI_ATTR][MEM_SH_FAST]))
    else $error("memory window 2 fast timing wrong");

  a_disabled_claim: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    bank[0][IDX_WIN_ENABLE] == 8'h00 ##1 bank[0][IDX_WIN_ENABLE] == 8'h00
    |-> !CYC_ATTR[0].claim)
    else $error("claim with all windows disabled");

  a_sock_b_isolated: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    wr_fire && acc_sock
    |=> bank[0][$past(acc_idx)] == $past(bank[0][acc_idx]))
    else $error("socket B write disturbed socket A");

  a_bus_answer: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && bus_state == BUS_IDLE
    |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer not one cycle after request");

  a_io0_start_edge: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && HOST_REQ.is_io && bank[0][IDX_WIN_ENABLE][EN_IO0_BIT]
    && HOST_REQ.addr[15:0] == {bank[0][IDX_IO_WIN0_START_HI], bank[0][IDX_IO_WIN0_START_LO]}
    && HOST_REQ.addr[15:0] <= {bank[0][IDX_IO_WIN0_END_HI], bank[0][IDX_IO_WIN0_END_LO]}
    |=> CYC_ATTR[0].claim && CYC_ATTR[0].win == 3'h0)
    else $error("io window 0 start address not claimed");

  a_io0_end_edge: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && HOST_REQ.is_io && bank[0][IDX_WIN_ENABLE][EN_IO0_BIT]
    && HOST_REQ.addr[15:0] == {bank[0][IDX_IO_WIN0_END_HI], bank[0][IDX_IO_WIN0_END_LO]}
    && HOST_REQ.addr[15:0] >= {bank[0][IDX_IO_WIN0_START_HI], bank[0][IDX_IO_WIN0_START_LO]}
    |=> CYC_ATTR[0].claim && CYC_ATTR[0].win == 3'h0)
    else $error("io window 0 end address not claimed");

  a_mem2_start_edge: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && !HOST_REQ.is_io && bank[0][IDX_WIN_ENABLE][2:0] == 3'h4
    && HOST_REQ.addr[23:MEM_GRAN_LSB] == {bank[0][IDX_MEM_WIN2_START_HI_ATTR][3:0],
                                          bank[0][IDX_MEM_WIN2_START_LO]}
    && HOST_REQ.addr[23:MEM_GRAN_LSB] <= {bank[0][mem_idx(3'h2, MEM_OFS_END_HI)][3:0],
                                          bank[0][mem_idx(3'h2, MEM_OFS_END_LO)]}
    |=> CYC_ATTR[0].claim && CYC_ATTR[0].win == 3'h2)
    else $error("memory window 2 start granule not claimed");

  a_mem2_end_edge: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && !HOST_REQ.is_io && bank[0][IDX_WIN_ENABLE][2:0] == 3'h4
    && HOST_REQ.addr[23:MEM_GRAN_LSB] == {bank[0][mem_idx(3'h2, MEM_OFS_END_HI)][3:0],
                                          bank[0][mem_idx(3'h2, MEM_OFS_END_LO)]}
    && HOST_REQ.addr[23:MEM_GRAN_LSB] >= {bank[0][IDX_MEM_WIN2_START_HI_ATTR][3:0],
                                          bank[0][IDX_MEM_WIN2_START_LO]}
    |=> CYC_ATTR[0].claim && CYC_ATTR[0].win == 3'h2)
    else $error("memory window 2 end granule not claimed");

  a_sock_b_auto: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && HOST_REQ.is_io && g_sock[1].io_hit[0] && g_sock[1].ctl[1]
    |=> CYC_ATTR[1].claim && CYC_ATTR[1].win == 3'h0
        && CYC_ATTR[1].wide == $past(card_wide[1]))
    else $error("socket B io window 0 width ignores card request");

  a_read_data: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    AVS_READ && bus_state == BUS_IDLE
    |=> AVS_READDATA == {24'h000000, $past(bank[acc_sock][acc_idx])})
    else $error("read data not the addressed register");

  a_mem_wait_add: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    HOST_REQ.valid && !HOST_REQ.is_io && g_sock[0].mem_hit[2:0] == 3'h4
    |=> CYC_ATTR[0].wait_add
        == ($past(bank[0][mem_idx(3'h2, MEM_OFS_END_HI)][MEM_EH_WS_MSB:MEM_EH_WS_LSB])
            & {2{CYC_ATTR[0].wide}}))
    else $error("memory window 2 wait states wrong");

  a_idle_attr_zero: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    !CYC_ATTR[0].claim |-> CYC_ATTR[0] == '0)
    else $error("unclaimed cycle carries attributes");

endmodule : cwa_window_bank

// file: cwa_card_model.sv
`timescale 1ns/100ps
module cwa_card_model #(
  parameter int unsigned LAG = 1
) (
  // clock
  input wire logic SYS_CLK,
  // bench asks for 16-bit, card answers on its pin
  input wire logic want_wide,
  output logic pin_n
);
  logic [LAG-1:0] pipe = '0;

  // a slow card settles its width pin some cycles after the bench asks
  always_ff @(posedge SYS_CLK) begin
    pipe <= (pipe << 1) | LAG'(want_wide);
  end

  assign pin_n = ~pipe[LAG-1];
endmodule : cwa_card_model

// file: cwa_window_bank_tb.sv
`timescale 1ns/100ps
module cwa_window_bank_tb import cwa_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] be = '0;
  logic [31:0] rdata;
  logic waitreq;
  cwa_host_req_t host = '0;
  logic [1:0] want = '0;
  logic [1:0] pin_n;
  cwa_cycle_attr_t [CWA_SOCKETS-1:0] attr;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [5:0] regs [19];

  cwa_window_bank i_cwa_window_bank (.SYS_CLK(clk), .RST(rst), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .HOST_REQ(host),
    .CARD_IO_WIDTH_REQUEST_N(pin_n), .CYC_ATTR(attr));
  cwa_card_model #(.LAG(1)) i_cwa_card_model (.SYS_CLK(clk), .want_wide(want[0]),
    .pin_n(pin_n[0]));
  // socket b card is a slow one
  cwa_card_model #(.LAG(5)) i_cwa_card_model_b (.SYS_CLK(clk), .want_wide(want[1]),
    .pin_n(pin_n[1]));

  always #10 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // upper write-data bytes are set on purpose: the slave must drop them
  task automatic bus(input logic w, input logic s, input logic [5:0] idx,
                     input logic [7:0] d, input logic [3:0] en, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {s, idx, 2'b00};
    wr <= w;
    rd <= !w;
    wdata <= {24'hffffff, d};
    be <= en;
    // read at the edge, before the slave updates: the value it samples itself
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      chk("bus answer", 32'h0, 32'h1);
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic wreg(input logic s, input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, s, idx, d, 4'h1, q);
  endtask : wreg

  task automatic rchk(input logic s, input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, s, idx, 8'h00, 4'h0, q);
    chk("register", q, {24'h0, e});
  endtask : rchk

  task automatic iowin(input logic s, input logic [5:0] idx, input logic [15:0] lo,
                       input logic [15:0] hi);
    wreg(s, idx, lo[7:0]);
    wreg(s, idx + 6'h1, lo[15:8]);
    wreg(s, idx + 6'h2, hi[7:0]);
    wreg(s, idx + 6'h3, hi[15:8]);
  endtask : iowin

  task automatic probe(input logic io, input logic [23:0] a, input cwa_cycle_attr_t e0,
                       input cwa_cycle_attr_t e1);
    @(posedge clk);
    host <= '{valid: 1'b1, is_io: io, addr: a};
    @(posedge clk);
    @(posedge clk);
    chk("attr socket a", 32'(attr[0]), 32'(e0));
    chk("attr socket b", 32'(attr[1]), 32'(e1));
  endtask : probe

  function automatic cwa_cycle_attr_t io_ex(logic [2:0] w, logic [3:0] c, logic p);
    logic wd;
    wd = c[IOC_AUTO] ? p : c[IOC_SIZE];
    io_ex = {2'b11, w, wd, !wd & c[IOC_FAST8], 1'b0, wd & c[IOC_WS16]};
  endfunction : io_ex

  task automatic t_regs;
    logic [31:0] q;
    chk("attr after reset", 32'(attr), 32'h0);
    for (int i = 0; i < 19; i++) begin
      rchk(0, regs[i], 8'h00);
      rchk(1, regs[i], 8'h00);
      wreg(0, regs[i], {2'b10, regs[i]});
      wreg(1, regs[i], ~{2'b10, regs[i]});
    end
    for (int i = 0; i < 19; i++) begin
      rchk(0, regs[i], {2'b10, regs[i]});
      rchk(1, regs[i], ~{2'b10, regs[i]});
    end
    bus(1'b1, 0, IDX_IO_TIMING_CTL, 8'h00, 4'h0, q);
    rchk(0, IDX_IO_TIMING_CTL, 8'h87);
    wreg(0, 6'h3f, 8'hff);
    rchk(0, 6'h3f, 8'h00);
  endtask : t_regs

  task automatic t_io;
    logic [3:0] h;
    iowin(0, IDX_IO_WIN0_START_LO, 16'h1234, 16'h1240);
    iowin(0, IDX_IO_WIN1_START_LO, 16'h2000, 16'h20ff);
    wreg(0, IDX_WIN_ENABLE, 8'hc0);
    for (int c = 0; c < 32; c++) begin
      h = 4'(c) ^ 4'h9;
      want[0] <= c[4];
      wreg(0, IDX_IO_TIMING_CTL, {h, 4'(c)});
      repeat (4) @(posedge clk);
      probe(1'b1, 24'h001240, io_ex(3'h0, 4'(c), c[4]), '0);
      probe(1'b1, 24'h002000, io_ex(3'h1, h, c[4]), '0);
    end
    wreg(0, IDX_IO_TIMING_CTL, 8'h00);
    probe(1'b1, 24'h001233, '0, '0);
    probe(1'b1, 24'h001234, io_ex(3'h0, 4'h0, 1'b0), '0);
    probe(1'b1, 24'h001241, '0, '0);
    probe(1'b1, 24'h0020ff, io_ex(3'h1, 4'h0, 1'b0), '0);
    wreg(0, IDX_WIN_ENABLE, 8'h80);
    probe(1'b1, 24'h001234, '0, '0);
    wreg(0, IDX_WIN_ENABLE, 8'h00);
    probe(1'b1, 24'h002000, '0, '0);
  endtask : t_io

  task automatic t_mem;
    logic [7:0] a;
    wreg(0, IDX_WIN_ENABLE, 8'h04);
    wreg(0, IDX_MEM_WIN2_START_LO, 8'h3c);
    wreg(0, 6'h22, 8'h40);
    wreg(0, 6'h23, 8'h05);
    for (int i = 0; i < 4; i++) begin
      // scratch bits run opposite to the attribute bits so a mix-up shows
      a = {2'(i), ~2'(i), 4'h5};
      wreg(0, IDX_MEM_WIN2_START_HI_ATTR, a);
      probe(1'b0, 24'h53c000, {2'b10, 3'h2, a[7], a[6], 2'b00}, '0);
    end
    // end high wait bits add three waits to the 16-bit window left by the loop
    wreg(0, 6'h23, 8'hf5);
    probe(1'b0, 24'h53bfff, '0, '0);
    probe(1'b0, 24'h540fff, {2'b10, 3'h2, 2'b11, 2'b11}, '0);
    probe(1'b0, 24'h541000, '0, '0);
    wreg(0, IDX_WIN_ENABLE, 8'h00);
  endtask : t_mem

  task automatic t_sock_b;
    iowin(1, IDX_IO_WIN0_START_LO, 16'h1234, 16'h1240);
    wreg(1, IDX_IO_TIMING_CTL, 8'h02);
    wreg(1, IDX_WIN_ENABLE, 8'h40);
    want[1] <= 1'b1;
    repeat (12) @(posedge clk);
    probe(1'b1, 24'h001234, '0, io_ex(3'h0, 4'h2, 1'b1));
  endtask : t_sock_b

  initial begin
    for (int i = 0; i < 9; i++) begin
      regs[i] = 6'(7 + i);
    end
    for (int i = 0; i < 10; i++) begin
      regs[9 + i] = {3'(2 + i / 2), 3'(i % 2)};
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_io();
    t_mem();
    t_sock_b();
    results();
  end

  // the whole run needs well under a third of this span
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule : cwa_window_bank_tb
